// *** logic/kbd_sideband_dev.sv ***
`include "kbd_sideband_defs.svh"
`timescale 1ns/10ps
`default_nettype none

// Device end: routes the four shared pins by mode and drives the CPU sideband outputs.
module kbd_sideband_dev
(
    // Clock and reset.
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    // Mode enables.
    input  wire logic          intKbdEnable,
    input  wire logic          mouseEnable,
    // Internal keyboard and mouse interface drive, active low enables.
    input  wire logic          kbdClkDrive,
    input  wire logic          kbdClkDriveOeN,
    input  wire logic          kbdDatDrive,
    input  wire logic          kbdDatDriveOeN,
    input  wire logic          mouseClkDrive,
    input  wire logic          mouseClkDriveOeN,
    input  wire logic          mouseDatDrive,
    input  wire logic          mouseDatDriveOeN,
    // Pin levels seen by the internal interfaces.
    output logic               kbdClkSeen,
    output logic               kbdDatSeen,
    output logic               mouseClkSeen,
    output logic               mouseDatSeen,
    // External controller signals recovered from the pins.
    output logic               extGateAddr20In,
    output logic               extKbdResetIn,
    output logic               extIrqLineOne,
    output logic               extIrqLineTwelve,
    // Event and level sources.
    input  wire logic          shutdownCycle,
    input  wire logic          softResetStart,
    input  wire logic          irqPending,
    input  wire logic          nmiTrigger,
    input  wire logic          smiEvent,
    input  wire logic          stopClkEvent,
    input  wire logic          addrMaskSrc,
    input  wire logic          ignoreErrSrc,
    // Processor sideband outputs, active high.
    output logic               processorResetOut,
    output logic               processorInitOut,
    output logic               processorIrqOut,
    output logic               processorNmiOut,
    output logic               sysMgmtIrqOut,
    output logic               stopClockOut,
    output logic               addr20MaskOut,
    output logic               ignoreFpuErrorOut,
    // Shared pins.
    kbd_sideband_if.device     pins
);

    kbd_sideband_pkg::dev_state_t stateReg;  // Registered state.
    kbd_sideband_pkg::dev_state_t stateNext; // Next state.

    // Pin drive is combinational on the enables so the device lets go in the
    // same cycle as the mode change; each driver needs both its mode on and its own active-low enable low.
    assign pins.devKbdClkOut   = kbdClkDrive;
    assign pins.devKbdClkOeN   = !intKbdEnable | kbdClkDriveOeN;
    assign pins.devKbdDatOut   = kbdDatDrive;
    assign pins.devKbdDatOeN   = !intKbdEnable | kbdDatDriveOeN;
    assign pins.devMouseClkOut = mouseClkDrive;
    assign pins.devMouseClkOeN = !mouseEnable | mouseClkDriveOeN;
    assign pins.devMouseDatOut = mouseDatDrive;
    assign pins.devMouseDatOeN = !mouseEnable | mouseDatDriveOeN;

    // Next-state logic for routing and processor sideband.
    always_comb
    begin
        stateNext = stateReg;
        // Internal interfaces see the wire only in their own mode, else idle high.
        stateNext.kbdClkIn   = intKbdEnable ? pins.kbdClockLine : 1'b1;
        stateNext.kbdDatIn   = intKbdEnable ? pins.kbdDataLine : 1'b1;
        stateNext.mouseClkIn = mouseEnable ? pins.mouseClockLine : 1'b1;
        stateNext.mouseDatIn = mouseEnable ? pins.mouseDataLine : 1'b1;
        // External controller roles; zero when the pin is not in that role.
        stateNext.gateA20      = !intKbdEnable && pins.kbdClockLine;
        stateNext.extKbdReset  = !intKbdEnable && pins.kbdDataLine;
        stateNext.extIrqOne    = !intKbdEnable && !mouseEnable
                                 && pins.mouseClockLine;
        stateNext.extIrqTwelve = !mouseEnable && pins.mouseDataLine;
        // Power-up reset: held for a fixed count after the bus reset releases.
        unique case (stateReg.rstState)
            kbd_sideband_pkg::RST_HOLD:
            begin
                stateNext.procReset = 1'b1;
                if (stateReg.rstCount == `CPU_RESET_CYCLES - 16'h0001)
                begin
                    stateNext.rstState  = kbd_sideband_pkg::RST_RUN;
                    stateNext.procReset = 1'b0;
                end
                else
                begin
                    stateNext.rstCount = stateReg.rstCount + 16'h0001;
                end
            end
            kbd_sideband_pkg::RST_RUN:
            begin
                stateNext.procReset = 1'b0;
            end
        endcase
        // Init pulse; a new trigger restarts it so none is lost.
        if (shutdownCycle || softResetStart)
        begin
            stateNext.initCount = `CPU_INIT_CYCLES;
        end
        else if (stateReg.initCount != 8'h00)
        begin
            stateNext.initCount = stateReg.initCount - 8'h01;
        end
        stateNext.procInit  = (shutdownCycle || softResetStart)
                              || (stateReg.initCount > 8'h01);
        stateNext.procIrq   = irqPending;
        stateNext.procNmi   = nmiTrigger;
        stateNext.sysMgmt   = smiEvent;
        stateNext.stopClk   = stopClkEvent;
        stateNext.addrMask  = addrMaskSrc;
        stateNext.ignoreErr = ignoreErrSrc;
    end

    // State register; reset returns to the power-up hold.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stateReg              <= '0;
            stateReg.rstState     <= kbd_sideband_pkg::RST_HOLD;
            stateReg.procReset    <= 1'b1;
            stateReg.kbdClkIn     <= 1'b1;
            stateReg.kbdDatIn     <= 1'b1;
            stateReg.mouseClkIn   <= 1'b1;
            stateReg.mouseDatIn   <= 1'b1;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    assign kbdClkSeen        = stateReg.kbdClkIn;
    assign kbdDatSeen        = stateReg.kbdDatIn;
    assign mouseClkSeen      = stateReg.mouseClkIn;
    assign mouseDatSeen      = stateReg.mouseDatIn;
    assign extGateAddr20In   = stateReg.gateA20;
    assign extKbdResetIn     = stateReg.extKbdReset;
    assign extIrqLineOne     = stateReg.extIrqOne;
    assign extIrqLineTwelve  = stateReg.extIrqTwelve;
    assign processorResetOut = stateReg.procReset;
    assign processorInitOut  = stateReg.procInit;
    assign processorIrqOut   = stateReg.procIrq;
    assign processorNmiOut   = stateReg.procNmi;
    assign sysMgmtIrqOut     = stateReg.sysMgmt;
    assign stopClockOut      = stateReg.stopClk;
    assign addr20MaskOut     = stateReg.addrMask;
    assign ignoreFpuErrorOut = stateReg.ignoreErr;

endmodule : kbd_sideband_dev

`default_nettype wire

// *** logic/kbd_sideband_defs.svh ***
// What this block does
// - Controller enabled: keyboard clock pin is clock
// - Controller disabled: clock pin carries external gate
// - Controller enabled: keyboard data pin is data
// - Controller disabled: data pin is reset request
// - Mouse enabled: mouse clock pin is clock
// - Both disabled: mouse clock pin is irq one
// - Mouse enabled: mouse data pin is data
// - Mouse disabled: mouse data pin is irq twelve
// - Processor reset asserted during power-up
// - Init pulse on shutdown special cycle
// - Init pulse on software soft reset
// - Interrupt output follows pending request
// - Nonmaskable interrupt follows error indication
// - System management interrupt on selected events
// - Stop clock on selected events
// - Address mask output mirrors its source
`ifndef KBD_SIDEBAND_DEFS_SVH
`define KBD_SIDEBAND_DEFS_SVH

// Cycles the processor reset stays asserted after power-up.
`define CPU_RESET_CYCLES 16'h0010
// Cycles of each processor initialization pulse.
`define CPU_INIT_CYCLES 8'h08
// Reset value of an active-high sideband output.
`define SIDEBAND_IDLE 1'b0

`endif

// *** logic/kbd_sideband_pkg.sv ***
package kbd_sideband_pkg;

    // Power-up reset sequencer states, one-hot.
    typedef enum logic [1:0]
    {
        RST_HOLD = 2'b01,
        RST_RUN  = 2'b10
    } rst_state_t;

    // Whole state of the device end.
    typedef struct packed
    {
        rst_state_t  rstState;
        logic [15:0] rstCount;
        logic [7:0]  initCount;
        logic        procReset;
        logic        procInit;
        logic        procIrq;
        logic        procNmi;
        logic        sysMgmt;
        logic        stopClk;
        logic        addrMask;
        logic        ignoreErr;
        logic        kbdClkIn;
        logic        kbdDatIn;
        logic        mouseClkIn;
        logic        mouseDatIn;
        logic        gateA20;
        logic        extKbdReset;
        logic        extIrqOne;
        logic        extIrqTwelve;
    } dev_state_t;

    // Whole state of the external keyboard controller end.
    typedef struct packed
    {
        logic kbdClkOut;
        logic kbdClkOe;
        logic kbdDatOut;
        logic kbdDatOe;
        logic mouseClkOut;
        logic mouseClkOe;
        logic mouseDatOut;
        logic mouseDatOe;
    } ext_state_t;

endpackage : kbd_sideband_pkg

// *** logic/kbd_sideband_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// Shared pins between the device and the external keyboard controller.
// Output enables are active low; the wire is the AND of low-enabled drivers, pulled high.
interface kbd_sideband_if;
    logic devKbdClkOut;
    logic devKbdClkOeN;
    logic devKbdDatOut;
    logic devKbdDatOeN;
    logic devMouseClkOut;
    logic devMouseClkOeN;
    logic devMouseDatOut;
    logic devMouseDatOeN;
    logic extKbdClkOut;
    logic extKbdClkOeN;
    logic extKbdDatOut;
    logic extKbdDatOeN;
    logic extMouseClkOut;
    logic extMouseClkOeN;
    logic extMouseDatOut;
    logic extMouseDatOeN;
    logic kbdClockLine;
    logic kbdDataLine;
    logic mouseClockLine;
    logic mouseDataLine;

    // Open-drain style resolution of each shared wire.
    assign kbdClockLine   = (devKbdClkOeN | devKbdClkOut) & (extKbdClkOeN | extKbdClkOut);
    assign kbdDataLine    = (devKbdDatOeN | devKbdDatOut) & (extKbdDatOeN | extKbdDatOut);
    assign mouseClockLine = (devMouseClkOeN | devMouseClkOut) & (extMouseClkOeN | extMouseClkOut);
    assign mouseDataLine  = (devMouseDatOeN | devMouseDatOut) & (extMouseDatOeN | extMouseDatOut);

    modport device
    (
        output devKbdClkOut, devKbdClkOeN, devKbdDatOut, devKbdDatOeN,
        output devMouseClkOut, devMouseClkOeN, devMouseDatOut, devMouseDatOeN,
        input  kbdClockLine, kbdDataLine, mouseClockLine, mouseDataLine
    );

    modport ext_ctrl
    (
        output extKbdClkOut, extKbdClkOeN, extKbdDatOut, extKbdDatOeN,
        output extMouseClkOut, extMouseClkOeN, extMouseDatOut, extMouseDatOeN,
        input  kbdClockLine, kbdDataLine, mouseClockLine, mouseDataLine
    );
endinterface : kbd_sideband_if

`default_nettype wire

// *** logic/kbd_sideband_ext.sv ***
`include "kbd_sideband_defs.svh"
`timescale 1ns/10ps
`default_nettype none

// External keyboard controller end: drives its sideband signals onto the
// shared pins the mode gives it, taking and releasing them one edge after each mode change.
module kbd_sideband_ext
(
    // Clock and reset.
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    // Mode straps shared with the device.
    input  wire logic          intKbdEnable,
    input  wire logic          mouseEnable,
    // Sideband levels this controller produces.
    input  wire logic          gateA20,
    input  wire logic          kbdResetReq,
    input  wire logic          irqOne,
    input  wire logic          irqTwelve,
    // Shared pins.
    kbd_sideband_if.ext_ctrl   pins
);

    kbd_sideband_pkg::ext_state_t stateReg;   // Registered pin drive.
    kbd_sideband_pkg::ext_state_t stateNext;  // Next pin drive.
    logic                         ownKbd;     // Keyboard pins belong to us.
    logic                         ownMouseClk; // Mouse clock pin belongs to us.

    // Decide pin ownership and drive each owned pin with its sideband level.
    always_comb
    begin
        ownKbd      = !intKbdEnable;
        ownMouseClk = !intKbdEnable && !mouseEnable;
        stateNext   = '0;
        stateNext.kbdClkOe    = !ownKbd;
        stateNext.kbdClkOut   = gateA20;
        stateNext.kbdDatOe    = !ownKbd;
        stateNext.kbdDatOut   = kbdResetReq;
        stateNext.mouseClkOe  = !ownMouseClk;
        stateNext.mouseClkOut = irqOne;
        stateNext.mouseDatOe  = mouseEnable;
        stateNext.mouseDatOut = irqTwelve;
    end

    // Register the drive; all enables released under reset.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stateReg <= '1;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    assign pins.extKbdClkOut   = stateReg.kbdClkOut;
    assign pins.extKbdClkOeN   = stateReg.kbdClkOe;
    assign pins.extKbdDatOut   = stateReg.kbdDatOut;
    assign pins.extKbdDatOeN   = stateReg.kbdDatOe;
    assign pins.extMouseClkOut = stateReg.mouseClkOut;
    assign pins.extMouseClkOeN = stateReg.mouseClkOe;
    assign pins.extMouseDatOut = stateReg.mouseDatOut;
    assign pins.extMouseDatOeN = stateReg.mouseDatOe;

endmodule : kbd_sideband_ext

`default_nettype wire

// *** dv/kbd_sideband_props.sv ***
`timescale 1ns/10ps
`default_nettype none

// Watches the four shared pins so that neither end drives out of its role.
module kbd_sideband_props
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Mode enables.
    input  wire logic intKbdEnable,
    input  wire logic mouseEnable,
    // Device end drivers.
    input  wire logic devKbdClkOeN,
    input  wire logic devKbdDatOeN,
    input  wire logic devMouseClkOeN,
    input  wire logic devMouseDatOeN,
    input  wire logic devMouseDatOut,
    // External end drivers.
    input  wire logic extKbdClkOeN,
    input  wire logic extKbdDatOeN,
    input  wire logic extMouseClkOeN,
    input  wire logic extMouseDatOeN,
    // Resolved wire.
    input  wire logic mouseDataLine
);
    // All checks share one clock; reset hides the hand-over after power-up.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_kbd_clk_released: assert property (!intKbdEnable |-> devKbdClkOeN)
        else $error("Device drives the keyboard clock pin while it is an input.");
    a_kbd_dat_released: assert property (!intKbdEnable |-> devKbdDatOeN)
        else $error("Device drives the keyboard data pin while it is an input.");
    a_mclk_released: assert property (!mouseEnable |-> devMouseClkOeN)
        else $error("Device drives the mouse clock pin outside mouse mode.");
    a_mdat_released: assert property (!mouseEnable |-> devMouseDatOeN)
        else $error("Device drives the mouse data pin outside mouse mode.");
    // The far end is registered, so it gets one edge to let go after a mode change.
    a_ext_kbd_quiet: assert property (intKbdEnable && $past(intKbdEnable) |->
        extKbdClkOeN && extKbdDatOeN)
        else $error("External end drives a keyboard pin in internal mode.");
    a_ext_mclk_quiet: assert property ((mouseEnable || intKbdEnable) &&
        $past(mouseEnable || intKbdEnable) |-> extMouseClkOeN)
        else $error("External end drives the mouse clock pin out of role.");
    a_ext_mdat_quiet: assert property (mouseEnable && $past(mouseEnable) |-> extMouseDatOeN)
        else $error("External end drives the mouse data pin in mouse mode.");
    // In its role the far end must drive, one edge after the mode and reset have settled.
    a_ext_kbd_drives: assert property (!intKbdEnable && $past(!intKbdEnable && !sys_rst) |->
        !extKbdClkOeN && !extKbdDatOeN)
        else $error("External end leaves a keyboard pin undriven in its role.");
    a_ext_mclk_drives: assert property (!intKbdEnable && !mouseEnable &&
        $past(!intKbdEnable && !mouseEnable && !sys_rst) |-> !extMouseClkOeN)
        else $error("External end leaves the mouse clock pin undriven in its role.");
    a_ext_mdat_drives: assert property (!mouseEnable && $past(!mouseEnable && !sys_rst) |->
        !extMouseDatOeN)
        else $error("External end leaves the mouse data pin undriven in its role.");
    a_mouse_low_seen: assert property (mouseEnable && $past(mouseEnable) &&
        !devMouseDatOeN && !devMouseDatOut |-> !mouseDataLine)
        else $error("Mouse data low drive does not reach the wire.");
endmodule : kbd_sideband_props

`default_nettype wire

// *** dv/kbd_sideband_logic_test.sv ***
`include "kbd_sideband_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module kbd_sideband_logic_test;
    logic       clk_sys, sys_rst, intKbdEnable, mouseEnable;  // Clock, reset, modes.
    logic       gateA20, kbdResetReq, irqOne, irqTwelve;      // External end levels.
    logic [7:0] drv;        // Internal pin drive, value then active-low enable, per pin.
    logic [5:0] lvl;        // Level sources towards the processor.
    logic       shutdownCycle, softResetStart;                // Init triggers.
    logic [3:0] seen;       // Pin levels seen by the device.
    logic [3:0] extIn;      // Signals recovered from the external end.
    logic [7:0] cpu;        // Reset, init, then the six level outputs.
    int         errors, tests_run, seed, highs;

    kbd_sideband_if pins ();

    kbd_sideband_dev kbd_sideband_dev_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .intKbdEnable(intKbdEnable), .mouseEnable(mouseEnable),
        .kbdClkDrive(drv[7]), .kbdClkDriveOeN(drv[6]), .kbdDatDrive(drv[5]),
        .kbdDatDriveOeN(drv[4]), .mouseClkDrive(drv[3]), .mouseClkDriveOeN(drv[2]),
        .mouseDatDrive(drv[1]), .mouseDatDriveOeN(drv[0]),
        .kbdClkSeen(seen[3]), .kbdDatSeen(seen[2]), .mouseClkSeen(seen[1]),
        .mouseDatSeen(seen[0]), .extGateAddr20In(extIn[3]), .extKbdResetIn(extIn[2]),
        .extIrqLineOne(extIn[1]), .extIrqLineTwelve(extIn[0]),
        .shutdownCycle(shutdownCycle), .softResetStart(softResetStart),
        .irqPending(lvl[5]), .nmiTrigger(lvl[4]), .smiEvent(lvl[3]),
        .stopClkEvent(lvl[2]), .addrMaskSrc(lvl[1]), .ignoreErrSrc(lvl[0]),
        .processorResetOut(cpu[7]), .processorInitOut(cpu[6]), .processorIrqOut(cpu[5]),
        .processorNmiOut(cpu[4]), .sysMgmtIrqOut(cpu[3]), .stopClockOut(cpu[2]),
        .addr20MaskOut(cpu[1]), .ignoreFpuErrorOut(cpu[0]), .pins(pins.device));

    kbd_sideband_ext kbd_sideband_ext_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .intKbdEnable(intKbdEnable), .mouseEnable(mouseEnable), .gateA20(gateA20),
        .kbdResetReq(kbdResetReq), .irqOne(irqOne), .irqTwelve(irqTwelve),
        .pins(pins.ext_ctrl));

    kbd_sideband_props kbd_sideband_props_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .intKbdEnable(intKbdEnable), .mouseEnable(mouseEnable),
        .devKbdClkOeN(pins.devKbdClkOeN), .devKbdDatOeN(pins.devKbdDatOeN),
        .devMouseClkOeN(pins.devMouseClkOeN), .devMouseDatOeN(pins.devMouseDatOeN),
        .devMouseDatOut(pins.devMouseDatOut), .extKbdClkOeN(pins.extKbdClkOeN),
        .extKbdDatOeN(pins.extKbdDatOeN), .extMouseClkOeN(pins.extMouseClkOeN),
        .extMouseDatOeN(pins.extMouseDatOeN), .mouseDataLine(pins.mouseDataLine));

    // Free-running system clock, 10 ns period.
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Expected wires, seen levels and recovered signals for one mode setting.
    // A pin that nobody drives floats to its pull-up, hence the ones.
    function automatic logic [11:0] pinExp(input logic k, m, g, r, i1, i12,
                                           input logic [7:0] d);
        logic kc, kd, mc, md;
        kc = d[7] | d[6];
        kd = d[5] | d[4];
        mc = d[3] | d[2];
        md = d[1] | d[0];
        return {k ? kc : g, k ? kd : r, m ? mc : (k | i1), m ? md : i12,
                k ? kc : 1'b1, k ? kd : 1'b1, m ? mc : 1'b1, m ? md : 1'b1,
                ~k & g, ~k & r, ~k & ~m & i1, ~m & i12};
    endfunction : pinExp

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Steps whole cycles and counts cycles with the init output high.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
            if (cpu[6] === 1'b1) highs++;
        end
    endtask : tick

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    // Applies a bus reset, then checks the processor reset at both ends of its hold.
    // The last-cycle check catches a hold that is one cycle short; the end check catches one that is one cycle long.
    task automatic resetRun;
        sys_rst = 1'b1;
        tick(12);
        check("reset during hold", 12'h001, {11'h000, cpu[7]});
        sys_rst = 1'b0;
        tick(`CPU_RESET_CYCLES - 1);
        check("reset last cycle", 12'h001, {11'h000, cpu[7]});
        tick(1);
        check("reset ends", 12'h000, {11'h000, cpu[7]});
    endtask : resetRun

    // The whole run is under a thousand cycles; this catches a hang.
    initial
    begin
        #50000;
        errors++;
        end_of_test;
    end

    initial
    begin
        seed = 20111;
        errors = 0;
        tests_run = 0;
        {intKbdEnable, mouseEnable} = 2'b11;
        {gateA20, kbdResetReq, irqOne, irqTwelve, shutdownCycle, softResetStart} = 6'h00;
        drv = 8'hff;
        lvl = 6'h00;
        resetRun;
        // First four passes: device pulls low every pin its mode gives it while the far end holds high.
        for (int i = 0; i < 204; i++)
        begin
            if (i < 4)
            begin
                {intKbdEnable, mouseEnable, gateA20, kbdResetReq, irqOne, irqTwelve} =
                    {i[1:0], 4'hf};
                drv = 8'h00;
            end
            else
            begin
                {intKbdEnable, mouseEnable, gateA20, kbdResetReq, irqOne, irqTwelve} =
                    6'($random(seed));
                drv = 8'($random(seed));
            end
            tick(3);
            check("pin routing", pinExp(intKbdEnable, mouseEnable, gateA20, kbdResetReq, irqOne,
                irqTwelve, drv), {pins.kbdClockLine, pins.kbdDataLine, pins.mouseClockLine,
                pins.mouseDataLine, seen, extIn});
        end
        repeat (50)
        begin
            lvl = 6'($random(seed));
            tick(1);
            check("processor levels", {6'h00, lvl}, {6'h00, cpu[5:0]});
        end
        // A second reset in mid-run, with random modes and levels still applied.
        resetRun;
        // Each trigger alone, then each retriggered four cycles later.
        for (int s = 0; s < 4; s++)
        begin
            highs = 0;
            {softResetStart, shutdownCycle} = s[0] ? 2'b10 : 2'b01;
            tick(1);
            {softResetStart, shutdownCycle} = 2'b00;
            if (s > 1)
            begin
                tick(3);
                shutdownCycle = 1'b1;
                tick(1);
                shutdownCycle = 1'b0;
            end
            tick(20);
            check("init width", 12'(s > 1 ? 4 + `CPU_INIT_CYCLES : `CPU_INIT_CYCLES), 12'(highs));
        end
        end_of_test;
    end
endmodule : kbd_sideband_logic_test

`default_nettype wire
